// ### hw/flash_protect_params.svh
// Offsets, field positions, reset values and address ranges of the unit
`ifndef FLASH_PROTECT_PARAMS_SVH
`define FLASH_PROTECT_PARAMS_SVH

`define STORED_PROT_ADDR    16'hFFBD
`define STORED_OPT_ADDR     16'hFFBF
`define KEY_BASE_ADDR       16'hFFB0
`define KEY_BYTES           4'h8
`define FLASH_BASE_ADDR     16'hE000
`define FLASH_LAST_ADDR     16'hFFFF
`define RAM_BASE_ADDR       16'h0060
`define RAM_LAST_ADDR       16'h025F
`define VEC_FIRST_ADDR      16'hFFC0
`define VEC_LAST_ADDR       16'hFFFD

`define FLASH_CFG_ADDR      16'h1823
`define WORK_PROT_ADDR      16'h1824
`define WORK_OPT_ADDR       16'h1821

`define OPT_BACKDOOR_ENABLE_BIT_BIT       7
`define OPT_NORED_BIT       6
`define OPT_SEC_HI          1
`define OPT_SEC_LO          0
`define PROT_DIS_BIT        0
`define CFG_KEY_ACCESS_MODE_BIT_BIT      5

`define WORK_PROT_RESET     8'hFF
`define WORK_OPT_RESET      8'hFF
`define FLASH_CFG_RESET     8'h00
`define SEC_OPEN            2'h2

`define CMD_BYTE_PROG       8'h20
`define CMD_BURST_PROG      8'h25
`define CMD_PAGE_ERASE      8'h40

`endif

// ### hw/flash_protect_pkg.sv
// Types shared by the flash protection and security unit
package flash_protect_pkg;

    typedef struct packed {
        logic [15:0] addr;
        logic        wr;
        logic        rd;
        logic [7:0]  wdata;
        logic        from_debug;
        logic        exec_secure;
    } bus_req_t;

    typedef enum logic [1:0] {
        LOAD_ISSUE,
        LOAD_CAPTURE,
        RUN
    } load_state_t;

endpackage

// ### hw/flash_protect_security_unit.sv
// Flash block protection, vector redirection and memory security unit
// What this block does
// - Program and erase inside the protected top region are blocked.
// - Working protection register loads from the stored protection byte.
// - Protection register writes accepted only from background debug.
// - Last unprotected address is boundary bits with low bits all one.
// - Protection active only when the disable bit 0 is zero.
// - Redirect enabled when the stored redirect-disable bit is zero.
// - Redirect only when some but not all flash is protected.
// - Redirect vectors 0xFFC0 to 0xFFFD, never the reset vector.
// - Secure: unsecured code or debug writes dropped, reads zero.
// - Code running from secure memory has unrestricted access.
// - Only security bits 1:0 mean unsecured; others mean secured.
// - Working option register loads from stored option byte at reset.
// - Secure keeps debug off; background mode only via reset strap.
// - Backdoor enable zero rejects every key unlock attempt.
// - Key access bit set makes secure-code key writes compare values only.
// - Key bit cleared with eight matching bytes sets security open.
// - Only secure-memory code may deliver compared key bytes.
// - Debug blank check of erased flash disengages security.
// - Stored registers and key are protected with the top block.
// - Three 8-bit flash control registers; two loaded from flash.
// - Secure debug: program and page erase commands raise error.
`timescale 1ns/1ps
`include "flash_protect_params.svh"

module flash_protect_security_unit
(
    input  wire logic                       core_clk,
    input  wire logic                       arst_n,
    input  wire flash_protect_pkg::bus_req_t bus_req,
    output logic                            bus_ready,
    output logic [7:0]                      bus_rdata,
    input  wire logic [7:0]                 mem_rdata,
    output logic                            mem_wr_en,
    output logic [15:0]                     nv_addr,
    input  wire logic [7:0]                 nv_rdata,
    input  wire logic                       pe_req,
    input  wire logic [15:0]                pe_addr,
    output logic                            pe_blocked,
    input  wire logic                       vec_fetch,
    input  wire logic [15:0]                vec_addr,
    output logic [15:0]                     vec_mapped_addr,
    input  wire logic                       cmd_wr,
    input  wire logic [7:0]                 cmd_code,
    output logic                            cmd_access_error,
    output logic                            key_write_capture,
    input  wire logic                       blank_check_done,
    input  wire logic                       blank_check_erased,
    input  wire logic                       debug_pin_mode_select,
    output logic                            debug_module_enable,
    output logic                            active_background_allowed,
    output logic                            secure
);

    logic [7:0]  working_protection_register;
    logic [7:0]  working_option_register;
    logic [7:0]  flash_config_register;
    logic [7:0]  backdoor_compare_bytes [0:7];
    logic [3:0]  load_idx;
    logic [3:0]  key_idx;
    logic        key_match;
    logic        key_gap;
    logic        pin_meta;
    logic        pin_sync;
    logic        strap_taken;
    logic        bg_strap_low;
    logic [15:0] last_unprot;
    logic        prot_on;
    logic        some_not_all;
    logic        redirect_on;
    logic        key_mode;
    logic        reg_hit;
    logic        mem_hit;
    logic        mem_allow;
    logic        key_hit;
    logic        key_access_mode_bit_fall;
    logic [7:0]  reg_rdata;
    flash_protect_pkg::load_state_t load_state;

    // Address decoding used by both the access gate and the key logic
    function automatic logic in_range(input logic [15:0] a,
                                      input logic [15:0] lo,
                                      input logic [15:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction

    function automatic logic [15:0] load_addr(input logic [3:0] idx);
        if (idx == 4'h0)
            load_addr = `STORED_PROT_ADDR;
        else if (idx == 4'h1)
            load_addr = `STORED_OPT_ADDR;
        else
            load_addr = `KEY_BASE_ADDR + {12'h000, idx - 4'h2};
    endfunction

    // Boundary bits over all-ones low bits
    assign last_unprot = {working_protection_register[7:1], 9'h1FF};
    assign prot_on = ~working_protection_register[`PROT_DIS_BIT];
    // Part, but not all, of flash protected
    assign some_not_all = prot_on && (last_unprot >= `FLASH_BASE_ADDR);
    // Stored redirect-disable bit low enables redirect
    assign redirect_on = some_not_all
                         && ~working_option_register[`OPT_NORED_BIT];

    // Only 1:0 is unsecured; load phase counts as secure
    assign secure = (load_state != flash_protect_pkg::RUN)
        || (working_option_register[`OPT_SEC_HI:`OPT_SEC_LO]
            != `SEC_OPEN);

    // Top block covers the stored bytes and the key
    assign pe_blocked = pe_req && prot_on
                        && (pe_addr > last_unprot)
                        && in_range(pe_addr, `FLASH_BASE_ADDR,
                                    `FLASH_LAST_ADDR);

    // Interrupt vectors only; reset pair passes through
    // Low six bits kept, upper bits from the boundary
    always_comb
    begin
        vec_mapped_addr = vec_addr;
        if (vec_fetch && redirect_on
            && in_range(vec_addr, `VEC_FIRST_ADDR, `VEC_LAST_ADDR))
            vec_mapped_addr = {last_unprot[15:6], vec_addr[5:0]};
    end

    // Secure debug byte program, burst program and page erase are refused
    assign cmd_access_error = cmd_wr && bus_req.from_debug && secure
        && (cmd_code == `CMD_BYTE_PROG || cmd_code == `CMD_BURST_PROG
            || cmd_code == `CMD_PAGE_ERASE);

    assign bus_ready = (load_state == flash_protect_pkg::RUN);
    assign key_mode  = flash_config_register[`CFG_KEY_ACCESS_MODE_BIT_BIT];
    assign reg_hit   = (bus_req.addr == `FLASH_CFG_ADDR)
                       || (bus_req.addr == `WORK_PROT_ADDR)
                       || (bus_req.addr == `WORK_OPT_ADDR);
    assign mem_hit   = in_range(bus_req.addr, `FLASH_BASE_ADDR,
                                `FLASH_LAST_ADDR)
                       || in_range(bus_req.addr, `RAM_BASE_ADDR,
                                   `RAM_LAST_ADDR);
    assign key_hit   = in_range(bus_req.addr, `KEY_BASE_ADDR,
                                `KEY_BASE_ADDR + 16'h0007);

    // Secure memory closed to debug and unsecured code
    // Code from secure memory always passes
    assign mem_allow = ~secure
        || (bus_req.exec_secure && ~bus_req.from_debug);

    // Key writes from secure-memory code in key mode never reach the flash array
    // Only secure-memory code delivers compared key bytes
    assign key_write_capture = bus_ready && bus_req.wr && key_mode
                               && key_hit && bus_req.exec_secure
                               && ~bus_req.from_debug;
    assign mem_wr_en = bus_ready && bus_req.wr && mem_hit && mem_allow
                       && ~key_write_capture;

    assign key_access_mode_bit_fall = bus_ready && bus_req.wr
        && (bus_req.addr == `FLASH_CFG_ADDR) && key_mode
        && ~bus_req.wdata[`CFG_KEY_ACCESS_MODE_BIT_BIT];

    // Flash configuration register, key access bit only writable
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            flash_config_register <= `FLASH_CFG_RESET;
        else if (bus_ready && bus_req.wr
                 && (bus_req.addr == `FLASH_CFG_ADDR))
            flash_config_register[`CFG_KEY_ACCESS_MODE_BIT_BIT]
                <= bus_req.wdata[`CFG_KEY_ACCESS_MODE_BIT_BIT];
    end

    // Reset load: protection byte, option byte, then the eight key bytes
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            load_state <= flash_protect_pkg::LOAD_ISSUE;
            load_idx   <= 4'h0;
            nv_addr    <= `STORED_PROT_ADDR;
        end
        else
        begin
            unique case (load_state)
                flash_protect_pkg::LOAD_ISSUE:
                begin
                    nv_addr    <= load_addr(load_idx);
                    load_state <= flash_protect_pkg::LOAD_CAPTURE;
                end
                flash_protect_pkg::LOAD_CAPTURE:
                begin
                    if (load_idx == `KEY_BYTES + 4'h1)
                        load_state <= flash_protect_pkg::RUN;
                    else
                    begin
                        load_idx   <= load_idx + 4'h1;
                        load_state <= flash_protect_pkg::LOAD_ISSUE;
                    end
                end
                flash_protect_pkg::RUN: load_state <= flash_protect_pkg::RUN;
            endcase
        end
    end

    // Stored key copy; no reset needed as it is always loaded first
    always_ff @(posedge core_clk)
    begin
        if (load_state == flash_protect_pkg::LOAD_CAPTURE
            && load_idx >= 4'h2)
            backdoor_compare_bytes[3'(load_idx - 4'h2)] <= nv_rdata;
    end

    // Protection loaded from the stored byte
    // Later writes only from background debug
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            working_protection_register <= `WORK_PROT_RESET;
        else if (load_state == flash_protect_pkg::LOAD_CAPTURE
                 && load_idx == 4'h0)
            working_protection_register <= nv_rdata;
        else if (bus_ready && bus_req.wr && bus_req.from_debug
                 && bus_req.addr == `WORK_PROT_ADDR)
            working_protection_register <= bus_req.wdata;
    end

    // Option byte copied during the load phase
    // Matching key forces the security bits open
    // Erased blank check via debug opens security
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            working_option_register <= `WORK_OPT_RESET;
        else if (load_state == flash_protect_pkg::LOAD_CAPTURE
                 && load_idx == 4'h1)
            working_option_register <= nv_rdata;
        else if ((blank_check_done && blank_check_erased
                  && bus_req.from_debug)
                 || (key_access_mode_bit_fall && key_match && key_idx == `KEY_BYTES
                     && working_option_register[`OPT_BACKDOOR_ENABLE_BIT_BIT]))
            working_option_register[`OPT_SEC_HI:`OPT_SEC_LO] <= `SEC_OPEN;
    end

    // Key sequence: ascending order, secure code only, one gap between
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            key_idx   <= 4'h0;
            key_match <= 1'b1;
            key_gap   <= 1'b1;
        end
        else if (!key_mode)
        begin
            key_idx   <= 4'h0;
            key_match <= 1'b1;
            key_gap   <= 1'b1;
        end
        else if (key_write_capture)
        begin
            key_gap <= 1'b0;
            // Out of order or back-to-back writes spoil it
            if (!key_gap
                || !working_option_register[`OPT_BACKDOOR_ENABLE_BIT_BIT]
                || key_idx >= `KEY_BYTES
                || bus_req.addr[3:0] != key_idx
                || bus_req.wdata != backdoor_compare_bytes[key_idx[2:0]])
                key_match <= 1'b0;
            if (key_idx < `KEY_BYTES)
                key_idx <= key_idx + 4'h1;
        end
        else
            key_gap <= 1'b1;
    end

    // Debug pin synchronised through two flops every cycle
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pin_meta <= 1'b1;
            pin_sync <= 1'b1;
        end
        else
        begin
            pin_meta <= debug_pin_mode_select;
            pin_sync <= pin_meta;
        end
    end

    // Strap is taken late by two flops; the pin must be held that long
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            strap_taken  <= 1'b0;
            bg_strap_low <= 1'b0;
        end
        else if (!strap_taken && load_state == flash_protect_pkg::RUN)
        begin
            strap_taken  <= 1'b1;
            bg_strap_low <= ~pin_sync;
        end
    end

    // On-chip debug stays off while secure
    assign debug_module_enable       = ~secure;
    assign active_background_allowed = bg_strap_low
                                       || (strap_taken && ~secure);

    always_comb
    begin
        reg_rdata = 8'h00;
        if (bus_req.addr == `FLASH_CFG_ADDR)
            reg_rdata = flash_config_register;
        else if (bus_req.addr == `WORK_PROT_ADDR)
            reg_rdata = working_protection_register;
        else if (bus_req.addr == `WORK_OPT_ADDR)
            reg_rdata = working_option_register;
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            bus_rdata <= 8'h00;
        else if (bus_ready && bus_req.rd)
        begin
            if (reg_hit)
                bus_rdata <= reg_rdata;
            else if (mem_hit && mem_allow)
                bus_rdata <= mem_rdata;
            else
                bus_rdata <= 8'h00;
        end
    end

endmodule

// ### sim/flash_protect_checker.sv
// Concurrent checks on the flash protection unit ports
`timescale 1ns/1ps
`include "flash_protect_params.svh"
module flash_protect_checker
(
    input wire logic                         core_clk,
    input wire logic                         arst_n,
    input wire flash_protect_pkg::bus_req_t  bus_req,
    input wire logic                         bus_ready,
    input wire logic [7:0]                   bus_rdata,
    input wire logic                         mem_wr_en,
    input wire logic                         vec_fetch,
    input wire logic [15:0]                  vec_addr,
    input wire logic [15:0]                  vec_mapped_addr,
    input wire logic                         cmd_wr,
    input wire logic [7:0]                   cmd_code,
    input wire logic                         cmd_access_error,
    input wire logic                         key_write_capture,
    input wire logic                         blank_check_done,
    input wire logic                         blank_check_erased,
    input wire logic                         debug_module_enable,
    input wire logic                         secure
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);
    sequence s_ready_on;
        bus_ready [*8];
    endsequence
    sequence s_stays_open;
        !secure [*8];
    endsequence
    chk_ready_hold: assert property ($rose(bus_ready) |=> s_ready_on)
        else $error("bus ready dropped after load");
    chk_unlock_sticks: assert property ($fell(secure) |=> s_stays_open)
        else $error("security came back before reset");
    chk_debug_off: assert property (debug_module_enable == !secure)
        else $error("debug module enabled while secure");
    chk_vec_low_bits: assert property (vec_fetch && vec_addr inside
        {[`VEC_FIRST_ADDR:`VEC_LAST_ADDR]}
        |-> vec_mapped_addr[5:0] == vec_addr[5:0])
        else $error("redirected vector lost its low bits");
    chk_other_kept: assert property (vec_fetch && !(vec_addr inside
        {[`VEC_FIRST_ADDR:`VEC_LAST_ADDR]}) |-> vec_mapped_addr == vec_addr)
        else $error("non-interrupt vector moved");
    chk_read_zeroed: assert property (bus_ready && bus_req.rd && secure
        && !bus_req.exec_secure && bus_req.addr inside
        {[`RAM_BASE_ADDR:`RAM_LAST_ADDR]} |=> bus_rdata == 8'h00)
        else $error("blocked read returned data");
    chk_write_dropped: assert property (bus_req.wr && secure
        && !bus_req.exec_secure |-> !mem_wr_en)
        else $error("blocked write reached memory");
    chk_key_no_write: assert property (key_write_capture |-> !mem_wr_en)
        else $error("key compare write reached memory");
    chk_key_source: assert property (key_write_capture |-> bus_req.wr
        && bus_req.exec_secure && !bus_req.from_debug)
        else $error("key captured from wrong source");
    chk_cmd_refused: assert property (cmd_wr && bus_req.from_debug
        && secure && cmd_code inside {8'h20, 8'h25, 8'h40}
        |-> cmd_access_error)
        else $error("secure debug command not refused");
    chk_blank_open: assert property (bus_ready && blank_check_done
        && blank_check_erased && bus_req.from_debug |=> !secure)
        else $error("erased blank check left security on");
endmodule

bind flash_protect_security_unit flash_protect_checker
    flash_protect_checker_inst (.core_clk, .arst_n, .bus_req, .bus_ready,
    .bus_rdata, .mem_wr_en, .vec_fetch, .vec_addr, .vec_mapped_addr,
    .cmd_wr, .cmd_code, .cmd_access_error, .key_write_capture,
    .blank_check_done, .blank_check_erased, .debug_module_enable, .secure);

// ### sim/flash_nv_model.sv
// Nonvolatile flash bytes read by the unit during its reset load
`timescale 1ns/1ps
module flash_nv_model
(
    input  wire logic [15:0] nv_addr,
    input  wire logic [7:0]  prot_byte,
    input  wire logic [7:0]  opt_byte,
    output logic      [7:0]  nv_rdata
);
    always_comb
    begin
        if (nv_addr == 16'hFFBD)
            nv_rdata = prot_byte;
        else if (nv_addr == 16'hFFBF)
            nv_rdata = opt_byte;
        else if (nv_addr[15:4] == 12'hFFB && !nv_addr[3])
            nv_rdata = 8'hC0 + {5'h00, nv_addr[2:0]};
        else
            nv_rdata = 8'hFF;
    end
endmodule

// ### sim/testbench.sv
// Self-checking bench for the flash protection and security unit
`timescale 1ns/1ps
`include "flash_protect_params.svh"
module testbench;
    logic                        core_clk = 1'b0;
    logic                        arst_n = 1'b0;
    flash_protect_pkg::bus_req_t bus_req = '0;
    logic [7:0]                  mem_rdata = 8'h5A;
    logic [7:0]                  prot_byte = 8'hFF;
    logic [7:0]                  opt_byte = 8'hFF;
    logic                        pe_req = 1'b0;
    logic [15:0]                 pe_addr = 16'h0000;
    logic                        vec_fetch = 1'b0;
    logic [15:0]                 vec_addr = 16'h0000;
    logic                        cmd_wr = 1'b0;
    logic [7:0]                  cmd_code = 8'h00;
    logic                        blank_check_done = 1'b0;
    logic                        blank_check_erased = 1'b0;
    logic                        debug_pin_mode_select = 1'b1;
    logic                        bus_ready, mem_wr_en, pe_blocked, secure;
    logic                        cmd_access_error, key_write_capture;
    logic                        debug_module_enable, active_background_allowed;
    logic [7:0]                  bus_rdata, nv_rdata;
    logic [15:0]                 nv_addr, vec_mapped_addr;
    logic                        wen, kcap;
    int                          err_total = 0;
    int                          compares = 0;
    int                          cyc = 0;

    flash_protect_security_unit flash_protect_security_unit_inst (.core_clk,
        .arst_n, .bus_req, .bus_ready, .bus_rdata, .mem_rdata, .mem_wr_en,
        .nv_addr, .nv_rdata, .pe_req, .pe_addr, .pe_blocked, .vec_fetch,
        .vec_addr, .vec_mapped_addr, .cmd_wr, .cmd_code, .cmd_access_error,
        .key_write_capture, .blank_check_done, .blank_check_erased,
        .debug_pin_mode_select, .debug_module_enable,
        .active_background_allowed, .secure);
    flash_nv_model flash_nv_model_inst (.nv_addr, .prot_byte, .opt_byte,
        .nv_rdata);

    always #2.5 core_clk = ~core_clk;

    // Whole run needs well under a thousand cycles
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 4000)
        begin
            err_total++;
            finish_test();
        end
    end

    task finish_test;
        if (err_total == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task chk(input logic [15:0] s, input logic [15:0] e);
        compares++;
        if (s !== e)
        begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask

    // Strap pin stays put until the synchroniser has seen it after load
    task do_reset(input logic [7:0] p, input logic [7:0] o, input logic pin);
        int n;
        @(negedge core_clk);
        arst_n = 1'b0;
        prot_byte = p;
        opt_byte = o;
        debug_pin_mode_select = pin;
        repeat (4) @(negedge core_clk);
        arst_n = 1'b1;
        for (n = 0; n < 40 && bus_ready !== 1'b1; n++)
            @(negedge core_clk);
        chk(bus_ready, 1'b1);
        repeat (2) @(negedge core_clk);
        debug_pin_mode_select = 1'b1;
    endtask

    // One access, then an idle cycle before the next may start
    task acc(input logic [15:0] a, input logic w, input logic [7:0] d,
             input logic dbg, input logic xs);
        @(negedge core_clk);
        bus_req = '{a, w, !w, d, dbg, xs};
        #1 wen = mem_wr_en;
        kcap = key_write_capture;
        @(negedge core_clk);
        bus_req = '0;
    endtask

    task t_protect;
        logic [7:0] codes [5];
        codes = '{8'h20, 8'h25, 8'h40, 8'h41, 8'h05};
        do_reset(8'hF8, 8'h83, 1'b1);
        chk(secure, 1'b1);
        chk(active_background_allowed, 1'b0);
        pe_req = 1'b1;
        vec_fetch = 1'b1;
        pe_addr = 16'hFA00;
        #1 chk(pe_blocked, 1'b1);
        pe_addr = 16'hF9FF;
        #1 chk(pe_blocked, 1'b0);
        pe_addr = `KEY_BASE_ADDR;
        #1 chk(pe_blocked, 1'b1);
        vec_addr = 16'hFFE0;
        #1 chk(vec_mapped_addr, 16'hF9E0);
        vec_addr = 16'hFFC0;
        #1 chk(vec_mapped_addr, 16'hF9C0);
        vec_addr = 16'hFFFE;
        #1 chk(vec_mapped_addr, 16'hFFFE);
        acc(`WORK_PROT_ADDR, 1'b0, 8'h00, 1'b1, 1'b0);
        chk(bus_rdata, 8'hF8);
        acc(`WORK_OPT_ADDR, 1'b1, 8'h00, 1'b1, 1'b0);
        acc(`WORK_OPT_ADDR, 1'b0, 8'h00, 1'b1, 1'b0);
        chk(bus_rdata, 8'h83);
        acc(`FLASH_CFG_ADDR, 1'b0, 8'h00, 1'b1, 1'b0);
        chk(bus_rdata, 8'h00);
        acc(`WORK_PROT_ADDR, 1'b1, 8'hFF, 1'b0, 1'b1);
        acc(`WORK_PROT_ADDR, 1'b0, 8'h00, 1'b1, 1'b0);
        chk(bus_rdata, 8'hF8);
        acc(`WORK_PROT_ADDR, 1'b1, 8'hFF, 1'b1, 1'b0);
        acc(`WORK_PROT_ADDR, 1'b0, 8'h00, 1'b1, 1'b0);
        chk(bus_rdata, 8'hFF);
        pe_addr = 16'hFFFF;
        #1 chk(pe_blocked, 1'b0);
        vec_addr = 16'hFFE0;
        #1 chk(vec_mapped_addr, 16'hFFE0);
        acc(`RAM_BASE_ADDR, 1'b0, 8'h00, 1'b1, 1'b0);
        chk(bus_rdata, 8'h00);
        acc(`RAM_BASE_ADDR, 1'b1, 8'h11, 1'b0, 1'b0);
        chk(wen, 1'b0);
        acc(`RAM_BASE_ADDR, 1'b0, 8'h00, 1'b0, 1'b1);
        chk(bus_rdata, 8'h5A);
        acc(`RAM_BASE_ADDR, 1'b1, 8'h11, 1'b0, 1'b1);
        chk(wen, 1'b1);
        foreach (codes[i])
        begin
            @(negedge core_clk);
            cmd_wr = 1'b1;
            cmd_code = codes[i];
            bus_req.from_debug = 1'b1;
            #1 chk(cmd_access_error, i < 3);
            @(negedge core_clk);
            cmd_wr = 1'b0;
            bus_req = '0;
        end
        pe_req = 1'b0;
        vec_fetch = 1'b0;
    endtask

    task t_key(input logic en, input logic dbg, input logic exp_sec);
        do_reset(8'hFF, {en, 7'h03}, 1'b1);
        acc(`FLASH_CFG_ADDR, 1'b1, 8'h20, 1'b0, 1'b1);
        for (int i = 0; i < 8; i++)
        begin
            acc(`KEY_BASE_ADDR + 16'(i), 1'b1, 8'hC0 + 8'(i), dbg, !dbg);
            chk(wen, 1'b0);
            if (en) chk(kcap, !dbg);
        end
        acc(`FLASH_CFG_ADDR, 1'b1, 8'h00, 1'b0, 1'b1);
        chk(secure, exp_sec);
        chk(debug_module_enable, !exp_sec);
        acc(`RAM_BASE_ADDR, 1'b0, 8'h00, 1'b1, 1'b0);
        chk(bus_rdata, exp_sec ? 8'h00 : 8'h5A);
    endtask

    task t_blank;
        do_reset(8'hF8, 8'h83, 1'b0);
        chk(active_background_allowed, 1'b1);
        acc(`WORK_PROT_ADDR, 1'b1, 8'hFF, 1'b1, 1'b0);
        for (int e = 0; e < 2; e++)
        begin
            @(negedge core_clk);
            bus_req.from_debug = 1'b1;
            blank_check_done = 1'b1;
            blank_check_erased = e[0];
            @(negedge core_clk);
            bus_req = '0;
            blank_check_done = 1'b0;
            chk(secure, !e[0]);
        end
    endtask

    initial
    begin
        t_protect();
        t_key(1'b1, 1'b1, 1'b1);
        t_key(1'b0, 1'b0, 1'b1);
        t_key(1'b1, 1'b0, 1'b0);
        t_blank();
        finish_test();
    end
endmodule
